// ===== logic/cbx_exec_top.sv
// Execution unit for arithmetic, logic, jump, call and skip operations
//
// Summary of operation
// - Register adds, optional carry, one cycle
// - Word add of constant, two cycles
// - Subtract register or constant, one cycle
// - Subtract with carry, register or constant
// - Word subtract of constant, two cycles
// - AND updates only zero, negative, overflow
// - OR and XOR update zero, negative, overflow
// - Invert and negate, carry flag updated
// - Set and clear bits by mask
// - Test, clear, step; all-ones keeps flags
// - Relative and indirect jumps, two cycles
// - Relative and indirect calls, three cycles
// - Compares set flags, write nothing
// - Skip next instruction when registers equal
// - Skip on general register bit
// - Skip on I/O register bit
// - I/O bit skips only below 0x20
`timescale 1ns/1ps
module cbx_exec_top (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_start,
  input  wire cbx_pkg::cbx_op_t i_op,
  input  wire logic [7:0]       i_rd,
  input  wire logic [7:0]       i_rr,
  input  wire logic [7:0]       i_imm,
  input  wire logic [15:0]      i_pair,
  input  wire logic [15:0]      i_ptr,
  input  wire logic [15:0]      i_pc,
  input  wire logic [11:0]      i_offset,
  input  wire logic [2:0]       i_bit_sel,
  input  wire logic [5:0]       i_io_addr,
  input  wire logic [7:0]       i_io_data,
  input  wire logic             i_next_two_word,
  output logic                  o_ready,
  output logic                  o_done,
  output logic                  o_wr_en,
  output logic [7:0]            o_result,
  output logic                  o_wr_word,
  output logic [15:0]           o_word_result,
  output logic [15:0]           o_pc_next,
  output logic                  o_push_en,
  output logic [15:0]           o_ret_addr,
  output logic [7:0]            o_flags,
  output logic                  o_io_range_err
);

  ////////////////////////////////////////////////////////////////////////
  // Operand selection and arithmetic units

  cbx_pkg::cbx_state_t state;
  cbx_pkg::cbx_state_t next_state;
  logic [1:0]          cnt;
  logic [1:0]          next_cnt;
  logic [1:0]          cyc;
  logic                take;
  logic [7:0]          a_op;
  logic [7:0]          b_op;
  logic                c_in;
  logic                sub;
  logic [7:0]          add_res;
  logic                add_c;
  logic                add_h;
  logic                add_v;
  logic                w_sub;
  logic [15:0]         w_res;
  logic                w_c;
  logic                w_z;
  logic                w_n;
  logic                w_v;
  logic                w_s;
  logic [15:0]         kimm;
  logic [15:0]         ofs_ext;
  logic                carry_in;
  logic                io_ok;
  logic                skip;
  logic [7:0]          lres;
  logic                next_done;
  logic                next_wr;
  logic [7:0]          next_result;
  logic                next_wword;
  logic [15:0]         next_word;
  logic [15:0]         next_pc;
  logic                next_push;
  logic [15:0]         next_ret;
  logic [7:0]          next_flags;
  logic                next_err;

  assign take     = i_start && o_ready;
  assign o_ready  = (state == cbx_pkg::ST_IDLE);
  assign kimm     = {10'h000, i_imm[5:0]};
  assign ofs_ext  = {{4{i_offset[11]}}, i_offset};
  assign carry_in = o_flags[cbx_pkg::FLG_C];
  assign io_ok    = (i_io_addr <= cbx_pkg::IO_BIT_MAX);
  assign w_sub    = (i_op == cbx_pkg::OP_SUBTRACT_WORD_IMMEDIATE);

  always_comb begin
    a_op = i_rd;
    b_op = i_rr;
    c_in = 1'b0;
    sub  = 1'b0;
    case (i_op)
      cbx_pkg::OP_ADD_CARRY: begin
        c_in = carry_in;
      end
      cbx_pkg::OP_SUB, cbx_pkg::OP_COMPARE: begin
        sub = 1'b1;
      end
      cbx_pkg::OP_DIFFERENCE_IMMEDIATE, cbx_pkg::OP_COMPARE_IMMEDIATE: begin
        b_op = i_imm;
        sub  = 1'b1;
      end
      cbx_pkg::OP_SUBTRACT_WITH_CARRY, cbx_pkg::OP_COMPARE_WITH_BORROW: begin
        sub  = 1'b1;
        c_in = carry_in;
      end
      cbx_pkg::OP_SUBTRACT_CARRY_CONSTANT: begin
        b_op = i_imm;
        sub  = 1'b1;
        c_in = carry_in;
      end
      cbx_pkg::OP_TWOS_INVERT: begin
        a_op = cbx_pkg::ALL_ZERO;
        b_op = i_rd;
        sub  = 1'b1;
      end
      cbx_pkg::OP_PLUS_ONE: begin
        b_op = cbx_pkg::STEP_ONE;
      end
      cbx_pkg::OP_MINUS_ONE: begin
        b_op = cbx_pkg::STEP_ONE;
        sub  = 1'b1;
      end
      default: begin
      end
    endcase
  end

  cbx_add8 u_add8 (
    .i_a     (a_op),
    .i_b     (b_op),
    .i_cin   (c_in),
    .i_sub   (sub),
    .o_res   (add_res),
    .o_carry (add_c),
    .o_half  (add_h),
    .o_ovf   (add_v)
  );

  cbx_word16 u_word16 (
    .i_pair (i_pair),
    .i_k    (kimm),
    .i_sub  (w_sub),
    .o_res  (w_res),
    .o_c    (w_c),
    .o_z    (w_z),
    .o_n    (w_n),
    .o_v    (w_v),
    .o_s    (w_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state, result and flag computation

  function automatic logic [7:0] set_znv(input logic [7:0] f,
                                         input logic [7:0] r,
                                         input logic       v);
    logic [7:0] t;
    t                 = f;
    t[cbx_pkg::FLG_Z] = (r == cbx_pkg::ALL_ZERO);
    t[cbx_pkg::FLG_N] = r[7];
    t[cbx_pkg::FLG_V] = v;
    return t;
  endfunction

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_done   = 1'b0;
    next_wr     = 1'b0;
    next_result = o_result;
    next_wword  = 1'b0;
    next_word   = o_word_result;
    next_pc     = o_pc_next;
    next_push   = 1'b0;
    next_ret    = o_ret_addr;
    next_flags  = o_flags;
    next_err    = 1'b0;
    cyc         = cbx_pkg::CYC_ONE;
    skip        = 1'b0;
    lres        = cbx_pkg::ALL_ZERO;
    case (state)
      cbx_pkg::ST_IDLE: begin
        if (i_start) begin
          next_pc = i_pc + cbx_pkg::PC_STEP;
          case (i_op)
            cbx_pkg::OP_ADD, cbx_pkg::OP_ADD_CARRY, cbx_pkg::OP_SUB,
            cbx_pkg::OP_DIFFERENCE_IMMEDIATE, cbx_pkg::OP_SUBTRACT_WITH_CARRY,
            cbx_pkg::OP_SUBTRACT_CARRY_CONSTANT, cbx_pkg::OP_TWOS_INVERT: begin
              next_wr                    = 1'b1;
              next_result                = add_res;
              next_flags                 = set_znv(o_flags, add_res, add_v);
              next_flags[cbx_pkg::FLG_C] = add_c;
              next_flags[cbx_pkg::FLG_H] = add_h;
            end
            cbx_pkg::OP_COMPARE, cbx_pkg::OP_COMPARE_WITH_BORROW,
            cbx_pkg::OP_COMPARE_IMMEDIATE: begin
              next_flags                 = set_znv(o_flags, add_res, add_v);
              next_flags[cbx_pkg::FLG_C] = add_c;
              next_flags[cbx_pkg::FLG_H] = add_h;
            end
            cbx_pkg::OP_PLUS_ONE, cbx_pkg::OP_MINUS_ONE: begin
              next_wr     = 1'b1;
              next_result = add_res;
              next_flags  = set_znv(o_flags, add_res, add_v);
            end
            cbx_pkg::OP_AND, cbx_pkg::OP_AND_WITH_CONSTANT,
            cbx_pkg::OP_OR, cbx_pkg::OP_OR_WITH_CONSTANT,
            cbx_pkg::OP_EXCLUSIVE_OR_REGISTERS, cbx_pkg::OP_SET_BITS_BY_MASK,
            cbx_pkg::OP_CLEAR_BITS_BY_MASK, cbx_pkg::OP_ZERO_SIGN_CHECK,
            cbx_pkg::OP_ZERO_REGISTER, cbx_pkg::OP_BITWISE_INVERT: begin
              case (i_op)
                cbx_pkg::OP_AND:                   lres = i_rd & i_rr;
                cbx_pkg::OP_AND_WITH_CONSTANT:     lres = i_rd & i_imm;
                cbx_pkg::OP_OR:                    lres = i_rd | i_rr;
                cbx_pkg::OP_OR_WITH_CONSTANT:      lres = i_rd | i_imm;
                cbx_pkg::OP_EXCLUSIVE_OR_REGISTERS: lres = i_rd ^ i_rr;
                cbx_pkg::OP_SET_BITS_BY_MASK:      lres = i_rd | i_imm;
                cbx_pkg::OP_CLEAR_BITS_BY_MASK:
                  lres = i_rd & (cbx_pkg::ALL_ONES - i_imm);
                cbx_pkg::OP_ZERO_SIGN_CHECK:       lres = i_rd & i_rd;
                cbx_pkg::OP_ZERO_REGISTER:         lres = i_rd ^ i_rd;
                default:                           lres = cbx_pkg::ALL_ONES - i_rd;
              endcase
              next_wr     = 1'b1;
              next_result = lres;
              next_flags  = set_znv(o_flags, lres, 1'b0);
              if (i_op == cbx_pkg::OP_BITWISE_INVERT) begin
                next_flags[cbx_pkg::FLG_C] = 1'b1;
              end
            end
            cbx_pkg::OP_ALL_ONES_REGISTER: begin
              next_wr     = 1'b1;
              next_result = cbx_pkg::ALL_ONES;
            end
            cbx_pkg::OP_ADD_WORD_IMMEDIATE,
            cbx_pkg::OP_SUBTRACT_WORD_IMMEDIATE: begin
              cyc                        = cbx_pkg::CYC_TWO;
              next_wword                 = 1'b1;
              next_word                  = w_res;
              next_flags[cbx_pkg::FLG_Z] = w_z;
              next_flags[cbx_pkg::FLG_C] = w_c;
              next_flags[cbx_pkg::FLG_N] = w_n;
              next_flags[cbx_pkg::FLG_V] = w_v;
              next_flags[cbx_pkg::FLG_S] = w_s;
            end
            cbx_pkg::OP_RELATIVE_JUMP: begin
              cyc     = cbx_pkg::CYC_TWO;
              next_pc = i_pc + ofs_ext + cbx_pkg::PC_STEP;
            end
            cbx_pkg::OP_INDIRECT_JUMP: begin
              cyc     = cbx_pkg::CYC_TWO;
              next_pc = i_ptr;
            end
            cbx_pkg::OP_RELATIVE_CALL, cbx_pkg::OP_INDIRECT_CALL: begin
              cyc       = cbx_pkg::CYC_THREE;
              next_push = 1'b1;
              next_ret  = i_pc + cbx_pkg::PC_STEP;
              next_pc   = (i_op == cbx_pkg::OP_INDIRECT_CALL) ? i_ptr
                          : i_pc + ofs_ext + cbx_pkg::PC_STEP;
            end
            cbx_pkg::OP_COMPARE_SKIP_EQUAL:  skip = (i_rd == i_rr);
            cbx_pkg::OP_SKIP_REG_BIT_CLEAR:  skip = !i_rr[i_bit_sel];
            cbx_pkg::OP_SKIP_REG_BIT_SET:    skip = i_rr[i_bit_sel];
            // Out-of-range I/O addresses never skip and raise an error pulse
            cbx_pkg::OP_SKIP_IO_BIT_CLEAR: begin
              skip     = io_ok && !i_io_data[i_bit_sel];
              next_err = !io_ok;
            end
            cbx_pkg::OP_SKIP_IO_BIT_SET: begin
              skip     = io_ok && i_io_data[i_bit_sel];
              next_err = !io_ok;
            end
            default: begin
            end
          endcase
          if (skip) begin
            cyc     = i_next_two_word ? cbx_pkg::CYC_THREE : cbx_pkg::CYC_TWO;
            next_pc = i_pc + (i_next_two_word ? cbx_pkg::SKIP_TWO_WORD
                                              : cbx_pkg::SKIP_ONE_WORD);
          end
          if (cyc == cbx_pkg::CYC_ONE) begin
            next_done = 1'b1;
          end else begin
            next_state = cbx_pkg::ST_WAIT;
            next_cnt   = cyc - cbx_pkg::CNT_LAST;
          end
        end
      end
      cbx_pkg::ST_WAIT: begin
        next_cnt = cnt - cbx_pkg::CNT_LAST;
        if (cnt == cbx_pkg::CNT_LAST) begin
          next_done  = 1'b1;
          next_state = cbx_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = cbx_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state          <= cbx_pkg::ST_IDLE;
      cnt            <= 2'h0;
      o_done         <= 1'b0;
      o_wr_en        <= 1'b0;
      o_result       <= 8'h00;
      o_wr_word      <= 1'b0;
      o_word_result  <= 16'h0000;
      o_pc_next      <= 16'h0000;
      o_push_en      <= 1'b0;
      o_ret_addr     <= 16'h0000;
      o_flags        <= cbx_pkg::FLAGS_RST;
      o_io_range_err <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      o_done         <= next_done;
      o_wr_en        <= next_wr;
      o_result       <= next_result;
      o_wr_word      <= next_wword;
      o_word_result  <= next_word;
      o_pc_next      <= next_pc;
      o_push_en      <= next_push;
      o_ret_addr     <= next_ret;
      o_flags        <= next_flags;
      o_io_range_err <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_single_done:
    assert property (take && cyc == cbx_pkg::CYC_ONE |=> o_done && o_ready)
    else $error("one-cycle operation did not finish next cycle");
  a_add_sum:
    assert property (take && i_op == cbx_pkg::OP_ADD
                     |=> o_wr_en && o_result == $past(i_rd) + $past(i_rr))
    else $error("add result wrong");
  a_word_add_time:
    assert property (take && i_op == cbx_pkg::OP_ADD_WORD_IMMEDIATE
                     |=> !o_done && !o_ready ##1 o_done)
    else $error("word add not two cycles");
  a_sub_flags:
    assert property (take && i_op == cbx_pkg::OP_SUB
                     |=> o_flags[cbx_pkg::FLG_C] == ($past(i_rd) < $past(i_rr)))
    else $error("subtract borrow wrong");
  a_sbc_value:
    assert property (take && i_op == cbx_pkg::OP_SUBTRACT_WITH_CARRY
                     |=> o_result == $past(i_rd) - $past(i_rr) - {7'h00, $past(carry_in)})
    else $error("subtract with carry wrong");
  a_word_sub_value:
    assert property (take && w_sub
                     |=> o_wr_word && o_word_result == $past(i_pair) - $past(kimm))
    else $error("word subtract wrong");
  a_and_flags:
    assert property (take && i_op == cbx_pkg::OP_AND
                     |=> !o_flags[cbx_pkg::FLG_V]
                         && o_flags[cbx_pkg::FLG_C] == $past(carry_in)
                         && o_flags[cbx_pkg::FLG_Z] == (o_result == 8'h00))
    else $error("and flags wrong");
  a_xor_value:
    assert property (take && i_op == cbx_pkg::OP_EXCLUSIVE_OR_REGISTERS
                     |=> o_result == ($past(i_rd) ^ $past(i_rr)))
    else $error("exclusive or wrong");
  a_invert_carry:
    assert property (take && i_op == cbx_pkg::OP_BITWISE_INVERT
                     |=> o_flags[cbx_pkg::FLG_C] && o_result == ~$past(i_rd))
    else $error("invert wrong");
  a_clear_mask:
    assert property (take && i_op == cbx_pkg::OP_CLEAR_BITS_BY_MASK
                     |=> o_result == ($past(i_rd) & ~$past(i_imm)))
    else $error("mask clear wrong");
  a_ones_keep:
    assert property (take && i_op == cbx_pkg::OP_ALL_ONES_REGISTER
                     |=> o_result == 8'hff && $stable(o_flags))
    else $error("all-ones changed flags");
  a_jump_target:
    assert property (take && i_op == cbx_pkg::OP_RELATIVE_JUMP
                     |=> o_pc_next == $past(i_pc) + $past(ofs_ext) + 16'h0001
                         && !o_done ##1 o_done)
    else $error("relative jump wrong");
  a_call_time:
    assert property (take && (i_op == cbx_pkg::OP_RELATIVE_CALL
                              || i_op == cbx_pkg::OP_INDIRECT_CALL)
                     |=> !o_done ##1 !o_done ##1 o_done)
    else $error("call not three cycles");
  a_cmp_nowrite:
    assert property (take && i_op == cbx_pkg::OP_COMPARE_IMMEDIATE
                     |=> !o_wr_en && !o_wr_word)
    else $error("compare wrote a register");
  a_skip_equal:
    assert property (take && i_op == cbx_pkg::OP_COMPARE_SKIP_EQUAL
                     && i_rd == i_rr && !i_next_two_word
                     |=> o_pc_next == $past(i_pc) + 16'h0002 && !o_done ##1 o_done)
    else $error("equal skip wrong");
  a_reg_noskip:
    assert property (take && i_op == cbx_pkg::OP_SKIP_REG_BIT_SET && !i_rr[i_bit_sel]
                     |=> o_done && o_pc_next == $past(i_pc) + 16'h0001)
    else $error("register bit skip wrong");
  a_io_flags:
    assert property (take && i_op == cbx_pkg::OP_SKIP_IO_BIT_CLEAR |=> $stable(o_flags))
    else $error("io skip changed flags");
  a_io_range:
    assert property (take && i_op == cbx_pkg::OP_SKIP_IO_BIT_SET && !io_ok
                     |=> o_io_range_err && o_pc_next == $past(i_pc) + 16'h0001)
    else $error("io range not enforced");
  a_two_word_skip:
    assert property (take && skip && i_next_two_word
                     |=> o_pc_next == $past(i_pc) + 16'h0003
                         && !o_done ##1 !o_done ##1 o_done)
    else $error("two-word skip wrong");

endmodule // cbx_exec_top

// ===== logic/cbx_pkg.sv
// Constants, operation codes and state codes of the execution unit
package cbx_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W   = 16;
  localparam int OFS_W  = 12;
  localparam int KW_W   = 6;
  localparam int FLG_C  = 0;
  localparam int FLG_Z  = 1;
  localparam int FLG_N  = 2;
  localparam int FLG_V  = 3;
  localparam int FLG_S  = 4;
  localparam int FLG_H  = 5;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [7:0]  ALL_ONES      = 8'hff;
  localparam logic [7:0]  ALL_ZERO      = 8'h00;
  localparam logic [7:0]  STEP_ONE      = 8'h01;
  localparam logic [15:0] PC_STEP       = 16'h0001;
  localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
  localparam logic [5:0]  IO_BIT_MAX    = 6'h1f;
  localparam logic [1:0]  CYC_ONE       = 2'h1;
  localparam logic [1:0]  CYC_TWO       = 2'h2;
  localparam logic [1:0]  CYC_THREE     = 2'h3;
  localparam logic [1:0]  CNT_LAST      = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } cbx_state_t;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_ADD_WORD_IMMEDIATE, OP_SUB,
    OP_DIFFERENCE_IMMEDIATE, OP_SUBTRACT_WITH_CARRY,
    OP_SUBTRACT_CARRY_CONSTANT, OP_SUBTRACT_WORD_IMMEDIATE,
    OP_AND, OP_AND_WITH_CONSTANT, OP_OR, OP_OR_WITH_CONSTANT,
    OP_EXCLUSIVE_OR_REGISTERS, OP_BITWISE_INVERT, OP_TWOS_INVERT,
    OP_SET_BITS_BY_MASK, OP_CLEAR_BITS_BY_MASK, OP_PLUS_ONE, OP_MINUS_ONE,
    OP_ZERO_SIGN_CHECK, OP_ZERO_REGISTER, OP_ALL_ONES_REGISTER,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_CALL,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_BORROW,
    OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET
  } cbx_op_t;
endpackage

// ===== logic/cbx_add8.sv
// Eight-bit adder and subtractor with carry, half-carry and overflow
`timescale 1ns/1ps
module cbx_add8 (
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  input  wire logic       i_sub,
  output logic      [7:0] o_res,
  output logic            o_carry,
  output logic            o_half,
  output logic            o_ovf
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] b_eff;
  logic       c_eff;

  // Borrow-in becomes inverted carry-in, so one adder serves both
  always_comb begin
    b_eff   = i_sub ? ~i_b : i_b;
    c_eff   = i_cin ^ i_sub;
    low     = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    sum     = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
    o_res   = sum[7:0];
    o_carry = sum[8] ^ i_sub;
    o_half  = low[4] ^ i_sub;
    o_ovf   = (i_a[7] == b_eff[7]) && (sum[7] != i_a[7]);
  end
endmodule // cbx_add8

// ===== logic/cbx_word16.sv
// Sixteen-bit pair add or subtract of a six-bit constant, with flags
`timescale 1ns/1ps
module cbx_word16 (
  input  wire logic [15:0] i_pair,
  input  wire logic [15:0] i_k,
  input  wire logic        i_sub,
  output logic      [15:0] o_res,
  output logic             o_c,
  output logic             o_z,
  output logic             o_n,
  output logic             o_v,
  output logic             o_s
);
  always_comb begin
    o_res = i_sub ? i_pair - i_k : i_pair + i_k;
    o_n   = o_res[15];
    o_z   = (o_res == 16'h0000);
    o_c   = i_sub ? (o_res[15] & ~i_pair[15]) : (~o_res[15] & i_pair[15]);
    o_v   = i_sub ? (i_pair[15] & ~o_res[15]) : (~i_pair[15] & o_res[15]);
    o_s   = o_n ^ o_v;
  end
endmodule // cbx_word16

// ===== bench/cbx_pc_keeper.sv
// Far-side model: program counter and call stack depth fed by the unit
`timescale 1ns/1ps
module cbx_pc_keeper (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_done,
  input  wire logic        i_push_en,
  input  wire logic [15:0] i_pc_next,
  output logic      [15:0] o_pc,
  output logic      [3:0]  o_depth
);
  // Loads only on completion, so a stale next-pc mid-operation goes unused
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pc    <= 16'h0000;
      o_depth <= 4'h0;
    end else begin
      if (i_done) o_pc <= i_pc_next;
      if (i_push_en) o_depth <= o_depth + 4'h1;
    end
  end
endmodule // cbx_pc_keeper

// ===== bench/cpu_alu_branch_skip_exec_test.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module cpu_alu_branch_skip_exec_test;
  typedef struct packed {
    cbx_pkg::cbx_op_t op;
    logic [7:0] rd, rr, imm, res;
    logic wr;
    logic [7:0] m, f;
  } cbx_row_t;
  typedef struct packed {
    cbx_pkg::cbx_op_t op;
    logic [7:0] rd, rr, iod;
    logic [2:0] bs;
    logic [5:0] ioa;
    logic two;
    logic [1:0] lat;
    logic [15:0] step;
  } cbx_skip_t;
  logic i_mclk = 0, i_rst_n = 0, i_start = 0, i_next_two_word = 0;
  cbx_pkg::cbx_op_t i_op = cbx_pkg::OP_ADD;
  logic [7:0] i_rd = 0, i_rr = 0, i_imm = 0, i_io_data = 0, o_result, o_flags;
  logic [15:0] i_pair = 0, i_ptr = 0, i_pc, o_word_result, o_pc_next, o_ret_addr;
  logic [11:0] i_offset = 0;
  logic [2:0] i_bit_sel = 0;
  logic [5:0] i_io_addr = 0;
  logic o_ready, o_done, o_wr_en, o_wr_word, o_push_en, o_io_range_err;
  logic [7:0] s_res, s_flags;
  logic [15:0] s_word, s_ret, exp_pc;
  logic s_wr, s_wrw, s_push, s_err;
  logic [3:0] depth;
  logic [1:0] lat;
  int n_errors = 0, comparisons = 0;
  always #10 i_mclk = ~i_mclk;
  cbx_exec_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
    .i_rd(i_rd), .i_rr(i_rr), .i_imm(i_imm), .i_pair(i_pair), .i_ptr(i_ptr), .i_pc(i_pc),
    .i_offset(i_offset), .i_bit_sel(i_bit_sel), .i_io_addr(i_io_addr),
    .i_io_data(i_io_data), .i_next_two_word(i_next_two_word), .o_ready(o_ready),
    .o_done(o_done), .o_wr_en(o_wr_en), .o_result(o_result), .o_wr_word(o_wr_word),
    .o_word_result(o_word_result), .o_pc_next(o_pc_next), .o_push_en(o_push_en),
    .o_ret_addr(o_ret_addr), .o_flags(o_flags), .o_io_range_err(o_io_range_err));
  cbx_pc_keeper keeper (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_done(o_done),
    .i_push_en(o_push_en), .i_pc_next(o_pc_next), .o_pc(i_pc), .o_depth(depth));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Outputs stand one cycle after the take, so they are sampled there
  task automatic go(input cbx_pkg::cbx_op_t op, input logic [1:0] elat);
    @(posedge i_mclk);
    i_op <= op;
    i_start <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    lat = 0;
    repeat (4) begin
      #1;
      lat++;
      if (lat == 1) {s_res, s_wr, s_flags, s_word, s_wrw, s_push, s_ret, s_err} =
        {o_result, o_wr_en, o_flags, o_word_result, o_wr_word, o_push_en, o_ret_addr,
         o_io_range_err};
      if (o_done === 1'b1) break;
      @(posedge i_mclk);
    end
    check("cycles", lat, elat);
    @(posedge i_mclk);
    #1;
    check("pc", i_pc, exp_pc);
    $display("test %0s done", op.name());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  cbx_row_t rows[] = '{
    '{cbx_pkg::OP_ADD, 8'h0f, 8'h01, 8'h00, 8'h10, 1, 8'h2f, 8'h20},
    '{cbx_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 8'h00, 1, 8'h2f, 8'h0b},
    '{cbx_pkg::OP_ADD_CARRY, 8'h01, 8'h01, 8'h00, 8'h03, 1, 8'h2f, 8'h00},
    '{cbx_pkg::OP_SUB, 8'h00, 8'h01, 8'h00, 8'hff, 1, 8'h2f, 8'h25},
    '{cbx_pkg::OP_SUBTRACT_WITH_CARRY, 8'h05, 8'h03, 8'h00, 8'h01, 1, 8'h2f, 8'h00},
    '{cbx_pkg::OP_DIFFERENCE_IMMEDIATE, 8'h10, 8'h00, 8'h10, 8'h00, 1, 8'h2f, 8'h02},
    '{cbx_pkg::OP_SUBTRACT_CARRY_CONSTANT, 8'h00, 8'h00, 8'h00, 8'h00, 1, 8'h2f, 8'h02},
    '{cbx_pkg::OP_AND, 8'hf0, 8'h3c, 8'h00, 8'h30, 1, 8'h0e, 8'h00},
    '{cbx_pkg::OP_AND_WITH_CONSTANT, 8'h80, 8'h00, 8'hff, 8'h80, 1, 8'h0e, 8'h04},
    '{cbx_pkg::OP_OR, 8'h00, 8'h00, 8'h00, 8'h00, 1, 8'h0e, 8'h02},
    '{cbx_pkg::OP_OR_WITH_CONSTANT, 8'h01, 8'h00, 8'h80, 8'h81, 1, 8'h0e, 8'h04},
    '{cbx_pkg::OP_EXCLUSIVE_OR_REGISTERS, 8'hff, 8'hff, 8'h00, 8'h00, 1, 8'h0e, 8'h02},
    '{cbx_pkg::OP_BITWISE_INVERT, 8'h00, 8'h00, 8'h00, 8'hff, 1, 8'h0f, 8'h05},
    '{cbx_pkg::OP_TWOS_INVERT, 8'h01, 8'h00, 8'h00, 8'hff, 1, 8'h2f, 8'h25},
    '{cbx_pkg::OP_SET_BITS_BY_MASK, 8'h01, 8'h00, 8'h02, 8'h03, 1, 8'h0e, 8'h00},
    '{cbx_pkg::OP_CLEAR_BITS_BY_MASK, 8'hff, 8'h00, 8'h0f, 8'hf0, 1, 8'h0e, 8'h04},
    '{cbx_pkg::OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h80, 1, 8'h0e, 8'h0c},
    '{cbx_pkg::OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7f, 1, 8'h0e, 8'h08},
    '{cbx_pkg::OP_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 8'h00, 1, 8'h0e, 8'h02},
    '{cbx_pkg::OP_ZERO_REGISTER, 8'h55, 8'h00, 8'h00, 8'h00, 1, 8'h0e, 8'h02},
    '{cbx_pkg::OP_ALL_ONES_REGISTER, 8'h00, 8'h00, 8'h00, 8'hff, 1, 8'h0e, 8'h02},
    '{cbx_pkg::OP_COMPARE, 8'h05, 8'h05, 8'h00, 8'h00, 0, 8'h2f, 8'h02},
    '{cbx_pkg::OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00, 0, 8'h2f, 8'h02},
    '{cbx_pkg::OP_COMPARE_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h00, 0, 8'h2f, 8'h25}};
  // Last row is the out-of-range I/O address, which must never skip
  cbx_skip_t skips[] = '{
    '{cbx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h05, 8'h05, 8'h00, 3'h0, 6'h00, 1, 2'h3, 16'h0003},
    '{cbx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h05, 8'h04, 8'h00, 3'h0, 6'h00, 1, 2'h1, 16'h0001},
    '{cbx_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'hfe, 8'h00, 3'h0, 6'h00, 0, 2'h2, 16'h0002},
    '{cbx_pkg::OP_SKIP_REG_BIT_SET, 8'h00, 8'h80, 8'h00, 3'h7, 6'h00, 1, 2'h3, 16'h0003},
    '{cbx_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h01, 3'h0, 6'h1f, 1, 2'h1, 16'h0001},
    '{cbx_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'h08, 3'h3, 6'h1f, 0, 2'h2, 16'h0002},
    '{cbx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h05, 8'h05, 8'h00, 3'h0, 6'h00, 0, 2'h2, 16'h0002},
    '{cbx_pkg::OP_SKIP_REG_BIT_SET, 8'h00, 8'h00, 8'h00, 3'h0, 6'h00, 0, 2'h1, 16'h0001},
    '{cbx_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'hff, 3'h3, 6'h20, 1, 2'h1, 16'h0001}};
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  initial begin
    exp_pc = 16'h0000;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    check("ready", o_ready, 1'b1);
    check("flags", o_flags, 8'h00);
    foreach (rows[i]) begin
      {i_rd, i_rr, i_imm} <= {rows[i].rd, rows[i].rr, rows[i].imm};
      exp_pc = exp_pc + 16'h0001;
      go(rows[i].op, 2'h1);
      check("wr", s_wr, rows[i].wr);
      if (rows[i].wr) check("res", s_res, rows[i].res);
      check("flags", s_flags & rows[i].m, rows[i].f);
    end
    {i_pair, i_imm} <= {16'h00ff, 8'h01};
    exp_pc = exp_pc + 16'h0001;
    go(cbx_pkg::OP_ADD_WORD_IMMEDIATE, 2'h2);
    check("word", {s_wrw, s_word, s_flags & 8'h1f}, {1'b1, 16'h0100, 8'h00});
    {i_pair, i_imm} <= {16'h0000, 8'h01};
    exp_pc = exp_pc + 16'h0001;
    go(cbx_pkg::OP_SUBTRACT_WORD_IMMEDIATE, 2'h2);
    check("word", {s_wrw, s_word, s_flags & 8'h1f}, {1'b1, 16'hffff, 8'h15});
    i_offset <= 12'hffe;
    exp_pc = exp_pc - 16'h0001;
    go(cbx_pkg::OP_RELATIVE_JUMP, 2'h2);
    i_ptr <= 16'h0040;
    exp_pc = 16'h0040;
    go(cbx_pkg::OP_INDIRECT_JUMP, 2'h2);
    i_offset <= 12'h005;
    exp_pc = 16'h0046;
    go(cbx_pkg::OP_RELATIVE_CALL, 2'h3);
    check("call", {s_push, s_ret}, {1'b1, 16'h0041});
    i_ptr <= 16'h0100;
    exp_pc = 16'h0100;
    go(cbx_pkg::OP_INDIRECT_CALL, 2'h3);
    check("call", {s_push, s_ret, depth}, {1'b1, 16'h0047, 4'h2});
    foreach (skips[i]) begin
      {i_rd, i_rr, i_io_data} <= {skips[i].rd, skips[i].rr, skips[i].iod};
      {i_bit_sel, i_io_addr, i_next_two_word} <= {skips[i].bs, skips[i].ioa, skips[i].two};
      exp_pc = exp_pc + skips[i].step;
      go(skips[i].op, skips[i].lat);
      check("ioerr", s_err, skips[i].ioa > 6'h1f);
    end
    check("flags", o_flags, 8'h35);
    test_done();
  end
endmodule // cpu_alu_branch_skip_exec_test
